// ===== rtl/pcf_config_frames.sv
/*
 configuration frames for channels 1 to 3 and the first bridge: frame
 check, storage, readback and the decoded settings the drivers use.
 assumes a 10 MHz clock, a bridge-enable level and overcurrent, switching
 and diagnostic-readout events from logic on the same clock.
*/
`timescale 1ns/1ps
module pcf_config_frames
    import pcf_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 spiClk,
    input  wire logic                 spiCsN,
    input  wire logic                 spiMosi,
    output logic                      spiMiso,
    input  wire logic                 bridge1Enable,
    input  wire logic                 diagReadout,
    input  wire logic [N_CH-1:0]      ocEvent,
    input  wire logic [N_CH-1:0]      ctrlSwitch,
    input  wire logic [N_CH-1:0][5:0] actualThreshold,
    output logic [N_CH-1:0]           chEnable,
    output logic [N_CH-1:0]           highSide,
    output logic [N_CH-1:0]           pChannel,
    output logic [N_CH-1:0]           olHighCurrent,
    output logic [N_CH-1:0]           senseShunt,
    output logic [N_CH-1:0]           blankGatesDetect,
    output logic [N_CH-1:0]           supplyAdjust,
    output logic [N_CH-1:0]           channelShutdown,
    output logic [N_CH-1:0][1:0]      tempAdjust,
    output logic [N_CH-1:0][1:0]      gateCurrent,
    output logic [N_CH-1:0][5:0]      thresholdCode,
    output logic [N_CH-1:0][TIME_W-1:0] diagCycles,
    output logic [N_CH-1:0][TIME_W-1:0] blankCycles,
    output logic                      supplyFactorPv,
    output logic                      limitActive,
    output logic [TIME_W-1:0]         limitOffCycles,
    output logic                      activeFreewheel,
    output logic                      frameError
);

    logic [N_CH-1:0][FRAME_W-1:0] cfg_ff;
    logic [FRAME_W-1:0]           respWord_ff;
    logic [2:0]                   tglSync_ff;
    logic [N_CH-1:0]              readDone_ff;
    logic [FRAME_W-1:0]           rxWord;
    logic                         rxToggle;
    logic                         newFrame;
    logic [3:0]                   rxCmd;
    logic                         cmdOk;
    logic                         parityOk;
    logic                         isRead;
    logic [1:0]                   rxIdx;
    logic                         hbTimer;

    // field positions and time tables are laid out for this frame shape only
    if (FRAME_W != 32) begin : gen_bad_frame
        $error("frame width must be 32");
    end
    if (N_CH != 3) begin : gen_bad_ch
        $error("exactly three channel frames are decoded");
    end
    if (TIME_W < 11) begin : gen_bad_time
        $error("time counts need at least 11 bits");
    end

    pcf_spi_link i_pcf_spi_link (
        .spiClk   (spiClk),
        .sysRst   (sys_rst),
        .spiCsN   (spiCsN),
        .spiMosi  (spiMosi),
        .spiMiso  (spiMiso),
        .txWord   (respWord_ff),
        .rxWord   (rxWord),
        .rxToggle (rxToggle)
    );

    function automatic logic [FRAME_W-1:0] withParity(input logic [FRAME_W-1:0] w);
        return {w[FRAME_W-1:1], ~^w[FRAME_W-1:1]};
    endfunction

    // overcurrent gate current boost; the external-resistor setting is left alone
    function automatic logic [1:0] boostGate(input logic [1:0] sel, input logic force20);
        logic [1:0] g;
        g = sel;
        if (sel == GATE_1) begin
            g = force20 ? GATE_20 : GATE_5;
        end else if (sel == GATE_5) begin
            g = GATE_20;
        end
        return g;
    endfunction

    // frame event crossing: first stage feeds only the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tglSync_ff <= 3'h0;
        end else begin
            tglSync_ff <= {tglSync_ff[1:0], rxToggle};
        end
    end

    // rxWord was loaded on the same edge that moved the toggle and holds, so it is safe to read here
    assign newFrame = tglSync_ff[2] ^ tglSync_ff[1];
    assign rxCmd    = rxWord[CMD_MSB:CMD_LSB];
    assign isRead   = rxWord[RW_BIT];
    assign parityOk = ^rxWord;
    assign cmdOk    = (rxCmd == CMD_CH1) || (rxCmd == CMD_CH2) ||
                      (rxCmd == CMD_CH3);
    assign rxIdx    = 2'(rxCmd - CMD_CH1);

    // writes need a good frame; a read-only frame leaves settings unchanged
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_ff <= {N_CH{CFG_RESET}};
        end else if (newFrame && parityOk && cmdOk && !isRead) begin
            cfg_ff[rxIdx] <= rxWord;
        end
    end

    // readback: the stored frame with the threshold field selectable
    always_ff @(posedge clock) begin
        logic [FRAME_W-1:0] d;
        d = CFG_RESET;
        if (sys_rst) begin
            respWord_ff <= CFG_RESET;
        end else if (newFrame) begin
            if (parityOk && cmdOk) begin
                d = isRead ? cfg_ff[rxIdx] : rxWord;
                if (d[THR_RD_BIT]) begin
                    d[THR_MSB:THR_LSB] = actualThreshold[rxIdx];
                end
            end
            d[CMD_MSB:CMD_LSB] = rxCmd;
            d[RW_BIT]          = isRead;
            respWord_ff <= withParity(d);
        end
    end

    // one-cycle pulse for a frame with bad parity or unknown command
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frameError <= 1'b0;
        end else begin
            frameError <= newFrame && !(parityOk && cmdOk);
        end
    end

    // extended bridge timing only while the bridge is built
    assign hbTimer = bridge1Enable && !cfg_ff[0][EXT_BIT];

    always_ff @(posedge clock) begin
        logic [1:0] code;
        code = 2'h0;
        if (sys_rst) begin
            diagCycles <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                code = hbTimer ? cfg_ff[0][DIAG_MSB:DIAG_LSB]
                               : cfg_ff[c][DIAG_MSB:DIAG_LSB];
                if (hbTimer) begin
                    diagCycles[c] <= nsToCyc(DIAG_HB_NS[code]);
                end else begin
                    diagCycles[c] <= nsToCyc(DIAG_STD_NS[code]);
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            thresholdCode <= '0;
            tempAdjust    <= '0;
            supplyAdjust  <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                thresholdCode[c] <= cfg_ff[c][THR_MSB:THR_LSB];
                tempAdjust[c]    <= cfg_ff[c][TEMP_MSB:TEMP_LSB];
                supplyAdjust[c]  <= cfg_ff[c][SUPPLY_BIT];
            end
        end
    end

    // shunt sensing detects at once; blanking then times only the diagnostic
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            blankCycles      <= '0;
            senseShunt       <= '0;
            blankGatesDetect <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                blankCycles[c]      <= nsToCyc(BLANK_NS[cfg_ff[c][BLANK_MSB:BLANK_LSB]]);
                senseShunt[c]       <= cfg_ff[c][SENSE_BIT];
                blankGatesDetect[c] <= !cfg_ff[c][SENSE_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            chEnable      <= '0;
            highSide      <= '0;
            pChannel      <= '0;
            olHighCurrent <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                chEnable[c]      <= cfg_ff[c][EN_BIT];
                highSide[c]      <= cfg_ff[c][SIDE_BIT];
                pChannel[c]      <= cfg_ff[c][PTYPE_BIT];
                olHighCurrent[c] <= cfg_ff[c][OL_BIT];
            end
        end
    end

    // boost holds while the channel sits in overcurrent shutdown
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gateCurrent <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                if (channelShutdown[c] || ocEvent[c]) begin
                    gateCurrent[c] <= boostGate(cfg_ff[c][GATE_MSB:GATE_LSB],
                                                cfg_ff[2][BOOST_BIT]);
                end else begin
                    gateCurrent[c] <= cfg_ff[c][GATE_MSB:GATE_LSB];
                end
            end
        end
    end

    // overcurrent latch; a new event beats a same-cycle release
    always_ff @(posedge clock) begin
        logic needRead;
        needRead = 1'b0;
        if (sys_rst) begin
            channelShutdown <= '0;
            readDone_ff     <= '0;
        end else begin
            for (int c = 0; c < N_CH; c++) begin
                needRead = bridge1Enable || cfg_ff[c][REENG_BIT];
                if (ocEvent[c]) begin
                    channelShutdown[c] <= 1'b1;
                    readDone_ff[c]     <= 1'b0;
                end else if (channelShutdown[c]) begin
                    if (ctrlSwitch[c] && (!needRead || readDone_ff[c])) begin
                        channelShutdown[c] <= 1'b0;
                        readDone_ff[c]     <= 1'b0;
                    end else if (diagReadout) begin
                        readDone_ff[c] <= 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            supplyFactorPv  <= 1'b0;
            limitOffCycles  <= '0;
            limitActive     <= 1'b0;
            activeFreewheel <= 1'b0;
        end else begin
            supplyFactorPv  <= cfg_ff[1][FACTOR_BIT];
            limitOffCycles  <= nsToCyc(TOFF_NS[cfg_ff[1][TOFF_MSB:TOFF_LSB]]);
            // limiting uses channel three's threshold, so it needs a shunt there
            limitActive     <= bridge1Enable && cfg_ff[2][LIMIT_BIT] &&
                               cfg_ff[2][SENSE_BIT];
            activeFreewheel <= cfg_ff[2][AFW_BIT];
        end
    end

endmodule

// ===== rtl/pcf_pkg.sv
/*
 package for the three channel configuration frames: frame field positions,
 command codes, time tables and the time-to-cycle conversion.
 assumes a 10 MHz system clock.
*/
package pcf_pkg;

    localparam int CLK_NS   = 100;
    localparam int TIME_W   = 12;
    localparam int FRAME_W  = 32;
    localparam int N_CH     = 3;

    // header
    localparam int CMD_MSB  = 31;
    localparam int CMD_LSB  = 28;
    localparam int RW_BIT   = 27;
    localparam int PAR_BIT  = 0;

    localparam logic [3:0] CMD_CH1 = 4'h1;
    localparam logic [3:0] CMD_CH2 = 4'h2;
    localparam logic [3:0] CMD_CH3 = 4'h3;

    // frame-specific bits
    localparam int TOFF_MSB   = 26;
    localparam int TOFF_LSB   = 25;
    localparam int EXT_BIT    = 24;
    localparam int FACTOR_BIT = 24;
    localparam int LIMIT_BIT  = 26;
    localparam int AFW_BIT    = 25;
    localparam int BOOST_BIT  = 24;

    // per-channel fields
    localparam int DIAG_MSB   = 23;
    localparam int DIAG_LSB   = 22;
    localparam int THR_RD_BIT = 21;
    localparam int THR_MSB    = 20;
    localparam int THR_LSB    = 15;
    localparam int TEMP_MSB   = 14;
    localparam int TEMP_LSB   = 13;
    localparam int SUPPLY_BIT = 12;
    localparam int BLANK_MSB  = 11;
    localparam int BLANK_LSB  = 9;
    localparam int REENG_BIT  = 8;
    localparam int SENSE_BIT  = 7;
    localparam int OL_BIT     = 6;
    localparam int GATE_MSB   = 5;
    localparam int GATE_LSB   = 4;
    localparam int PTYPE_BIT  = 3;
    localparam int SIDE_BIT   = 2;
    localparam int EN_BIT     = 1;

    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // gate current codes
    localparam logic [1:0] GATE_EXT = 2'h0;
    localparam logic [1:0] GATE_20  = 2'h1;
    localparam logic [1:0] GATE_5   = 2'h2;
    localparam logic [1:0] GATE_1   = 2'h3;

    // times in ns
    localparam int DIAG_STD_NS [4] = '{25600, 61200, 105600, 150000};
    localparam int DIAG_HB_NS  [4] = '{11200, 28900, 40000, 51200};
    localparam int BLANK_NS    [8] = '{11100, 15600, 20000, 31100,
                                       42200, 53300, 97800, 142200};
    localparam int TOFF_NS     [4] = '{31000, 48000, 62500, 125000};

    // least times: round up, never below one cycle
    function automatic logic [TIME_W-1:0] nsToCyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) c = 1;
        return TIME_W'(c);
    endfunction

endpackage

// ===== rtl/pcf_spi_link.sv
/*
 serial link end: 32-bit frames, msb first, on the host's link clock.
 assumes the host launches on the rising edge and samples on the falling
 edge, with exactly 32 clocks per chip-select low period.
*/
`timescale 1ns/1ps
module pcf_spi_link
    import pcf_pkg::*;
(
    input  wire logic               spiClk,
    input  wire logic               sysRst,
    input  wire logic               spiCsN,
    input  wire logic               spiMosi,
    output logic                    spiMiso,
    input  wire logic [FRAME_W-1:0] txWord,
    output logic [FRAME_W-1:0]      rxWord,
    output logic                    rxToggle
);

    logic [1:0]         rstSync_ff;
    logic [4:0]         bitCnt_ff;
    logic [FRAME_W-1:0] shift_ff;
    logic               linkRst;

    // reset level brought into the link domain
    always_ff @(posedge spiClk) begin
        rstSync_ff <= {rstSync_ff[0], sysRst};
    end
    assign linkRst = rstSync_ff[1];

    // wraps to zero after a full frame; a cut frame leaves it misaligned
    always_ff @(posedge spiClk) begin
        if (linkRst) begin
            bitCnt_ff <= 5'h00;
        end else if (!spiCsN) begin
            bitCnt_ff <= bitCnt_ff + 5'h01;
        end
    end

    // txWord only changes after a frame lands, so it is stable here
    always_ff @(posedge spiClk) begin
        if (linkRst) begin
            spiMiso <= 1'b0;
        end else if (!spiCsN) begin
            spiMiso <= txWord[5'h1F - bitCnt_ff];
        end
    end

    always_ff @(negedge spiClk) begin
        if (!spiCsN) begin
            shift_ff <= {shift_ff[FRAME_W-2:0], spiMosi};
        end
    end

    // last bit: counter already wrapped by the preceding rising edge
    always_ff @(negedge spiClk) begin
        if (linkRst) begin
            rxToggle <= 1'b0;
            rxWord   <= CFG_RESET;
        end else if (!spiCsN && bitCnt_ff == 5'h00) begin
            rxWord   <= {shift_ff[FRAME_W-2:0], spiMosi};
            rxToggle <= ~rxToggle;
        end
    end

endmodule

// ===== verification/pcf_spi_host.sv
/*
 host model for the serial link: one 32-bit frame, msb first, answer kept.
 assumes the device drives on rising and samples on falling link edges.
*/
`timescale 1ns/1ps
module pcf_spi_host (
    output logic      spiClk,
    output logic      spiCsN,
    output logic      spiMosi,
    input  wire logic spiMiso
);
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    // select stays high: only lets the link domain see reset
    task automatic tick(input int n);
        repeat (n) begin
            #32 spiClk = 1'b1;
            #32 spiClk = 1'b0;
        end
    endtask
    task automatic xfer(input logic [31:0] v, output logic [31:0] r);
        spiCsN = 1'b0;
        for (int k = 31; k >= 0; k--) begin
            #32 spiClk = 1'b1;
            spiMosi = v[k];
            #32 r[k] = spiMiso;
            spiClk = 1'b0;
        end
        #32 spiCsN = 1'b1;
        // released line flips so stale data cannot pass as valid
        spiMosi = ~spiMosi;
        #1200;
    endtask
endmodule

// ===== verification/pcf_config_frames_sva.sv
/*
 checker for the frame block: overcurrent latch, bridge re-engagement,
 decoded time tables, error pulse.
 assumes it is bound to pcf_config_frames.
*/
`timescale 1ns/1ps
module pcf_config_frames_sva
    import pcf_pkg::*;
(
    input wire logic                         clock,
    input wire logic                         sys_rst,
    input wire logic                         bridge1Enable,
    input wire logic                         diagReadout,
    input wire logic [N_CH-1:0]              ocEvent,
    input wire logic [N_CH-1:0]              ctrlSwitch,
    input wire logic [N_CH-1:0]              channelShutdown,
    input wire logic [N_CH-1:0]              senseShunt,
    input wire logic [N_CH-1:0]              blankGatesDetect,
    input wire logic [N_CH-1:0][TIME_W-1:0]  diagCycles,
    input wire logic [TIME_W-1:0]            limitOffCycles,
    input wire logic                         limitActive,
    input wire logic                         frameError
);
    logic [1:0] rstD_ff;
    logic       rdSeen_ff;
    // outputs settle one clock after release; disable iff reads current values,
    // so both edges after release are skipped
    always_ff @(posedge clock) rstD_ff <= {rstD_ff[0], sys_rst};
    always_ff @(posedge clock) begin
        if (sys_rst || !channelShutdown[2]) rdSeen_ff <= 1'b0;
        else if (diagReadout) rdSeen_ff <= 1'b1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst || (rstD_ff != 2'h0));
    AST_SHUT_SET: assert property (ocEvent[2] |=> channelShutdown[2])
        else $error("shutdown not latched");
    AST_SHUT_HOLD: assert property (channelShutdown[2] && !ctrlSwitch[2]
        |=> channelShutdown[2]) else $error("shutdown left without switching");
    AST_BRIDGE: assert property (channelShutdown[2] && bridge1Enable
        && !rdSeen_ff && !diagReadout |=> channelShutdown[2])
        else $error("bridge re-engaged without readout");
    AST_LIMIT: assert property (limitActive
        |-> senseShunt[2] && $past(bridge1Enable)) else $error("limit without shunt");
    AST_ERR: assert property (frameError |=> !frameError)
        else $error("error flag longer than one cycle");
    AST_DIAG: assert property (diagCycles[0] inside {12'h100, 12'h264,
        12'h420, 12'h5DC, 12'h070, 12'h121, 12'h190, 12'h200})
        else $error("timer value off table");
    AST_HB_SAME: assert property (diagCycles[0] inside {12'h070, 12'h121,
        12'h190, 12'h200} |-> diagCycles[1] == diagCycles[0]
        && diagCycles[2] == diagCycles[0]) else $error("bridge timer not shared");
    AST_BLANK: assert property (blankGatesDetect == ~senseShunt)
        else $error("blanking gate wrong for sense method");
    AST_TOFF: assert property (limitOffCycles inside {12'h136, 12'h1E0,
        12'h271, 12'h4E2}) else $error("off time off table");
endmodule
bind pcf_config_frames pcf_config_frames_sva i_pcf_config_frames_sva (
    .clock, .sys_rst, .bridge1Enable, .diagReadout, .ocEvent, .ctrlSwitch,
    .channelShutdown, .senseShunt, .blankGatesDetect, .diagCycles,
    .limitOffCycles, .limitActive, .frameError
);

// ===== verification/pcf_config_frames_tb.sv
/*
 testbench for the frame block: frames through the host model, settings
 and answers compared with expected tables.
 assumes pcf_spi_host as far side, 10 MHz clock.
*/
`timescale 1ns/1ps
module pcf_config_frames_tb
    import pcf_pkg::*;
;
    localparam logic [11:0] BL [8] = '{12'h06F, 12'h09C, 12'h0C8, 12'h137,
                                      12'h1A6, 12'h215, 12'h3D2, 12'h58E};
    localparam logic [11:0] DS [4] = '{12'h100, 12'h264, 12'h420, 12'h5DC};
    localparam logic [11:0] TO [4] = '{12'h136, 12'h1E0, 12'h271, 12'h4E2};
    logic                        clock, sys_rst, spiClk, spiCsN, spiMosi, spiMiso;
    logic                        bridge1Enable, diagReadout, supplyFactorPv;
    logic                        limitActive, activeFreewheel, frameError;
    logic [N_CH-1:0]             ocEvent, ctrlSwitch, chEnable, highSide, pChannel;
    logic [N_CH-1:0]             olHighCurrent, senseShunt, blankGatesDetect;
    logic [N_CH-1:0]             supplyAdjust, channelShutdown;
    logic [N_CH-1:0][1:0]        tempAdjust, gateCurrent;
    logic [N_CH-1:0][5:0]        actualThreshold, thresholdCode;
    logic [N_CH-1:0][TIME_W-1:0] diagCycles, blankCycles;
    logic [TIME_W-1:0]           limitOffCycles;
    logic [31:0]                 rsp, prev, w;
    int                          mismatches, n_compared, errCnt;
    pcf_config_frames i_pcf_config_frames (
        .clock, .sys_rst, .spiClk, .spiCsN, .spiMosi, .spiMiso, .bridge1Enable,
        .diagReadout, .ocEvent, .ctrlSwitch, .actualThreshold, .chEnable,
        .highSide, .pChannel, .olHighCurrent, .senseShunt, .blankGatesDetect,
        .supplyAdjust, .channelShutdown, .tempAdjust, .gateCurrent,
        .thresholdCode, .diagCycles, .blankCycles, .supplyFactorPv,
        .limitActive, .limitOffCycles, .activeFreewheel, .frameError
    );
    pcf_spi_host i_pcf_spi_host (.spiClk, .spiCsN, .spiMosi, .spiMiso);
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) if (frameError === 1'b1) errCnt++;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] fr(input logic [31:0] v);
        return {v[31:1], ~^v[31:1]};
    endfunction
    task automatic send(input logic [31:0] v);
        i_pcf_spi_host.xfer(fr(v), rsp);
    endtask
    task automatic pulse(input logic [2:0] oc, input logic [2:0] sw, input logic rd);
        @(posedge clock);
        ocEvent <= oc;
        ctrlSwitch <= sw;
        diagReadout <= rd;
        @(posedge clock);
        ocEvent <= 3'h0;
        ctrlSwitch <= 3'h0;
        diagReadout <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #500000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        logic [2:0] b;
        sys_rst = 1'b1;
        bridge1Enable = 1'b0;
        diagReadout = 1'b0;
        ocEvent = 3'h0;
        ctrlSwitch = 3'h0;
        actualThreshold = {6'h2A, 6'h15, 6'h0B};
        fork
            i_pcf_spi_host.tick(4);
            repeat (4) @(posedge clock);
        join
        sys_rst <= 1'b0;
        i_pcf_spi_host.tick(3);
        @(posedge clock);
        chk({diagCycles[0], blankCycles[2]}, {DS[0], BL[0]});
        chk(limitOffCycles, TO[0]);
        chk(blankGatesDetect, 3'h7);
        // every code of every field on channel two but enable, threshold readback and threshold codes above 7
        for (int i = 0; i < 8; i++) begin
            b = i[2:0];
            w = {4'h2, 1'b0, b[1:0], b[0], b[1:0], 1'b0, 3'h0, b, b[1:0], b[0], b,
                 b[0], b[0], b[1], b[1:0], b[2], b[1], 1'b1, 1'b0};
            send(w);
            if (i > 0) chk(rsp, prev);
            prev = fr(w);
            chk(blankCycles[1], BL[i]);
            chk(diagCycles[1], DS[b[1:0]]);
            chk(limitOffCycles, TO[b[1:0]]);
            chk({supplyFactorPv, supplyAdjust[1]}, {b[0], b[0]});
            chk(thresholdCode[1], {3'h0, b});
            chk(tempAdjust[1], b[1:0]);
            chk(gateCurrent[1], b[1:0]);
            chk({senseShunt[1], blankGatesDetect[1]}, {b[0], ~b[0]});
            chk(olHighCurrent[1], b[1]);
            chk({pChannel[1], highSide[1], chEnable[1]}, {b[2], b[1], 1'b1});
        end
        send({4'h2, 1'b1, 27'h5555555});
        chk(rsp, prev);
        chk(blankCycles[1], BL[7]);
        prev = fr({4'h2, 1'b1, w[26:0]});
        i_pcf_spi_host.xfer(fr({4'h2, 28'h0}) ^ 32'h1, rsp);
        chk(rsp, prev);
        chk(chEnable[1], 1'b1);
        send({4'h0, 28'h0});
        chk(rsp, fr({4'h2, 28'h0}));
        chk(errCnt, 2);
        @(posedge clock);
        bridge1Enable <= 1'b1;
        send({4'h1, 4'h0, 2'h2, 22'h0});
        send({4'h3, 4'h7, 2'h0, 1'b1, 6'h05, 6'h0, 3'h2, 2'h3, 3'h1, 1'b0});
        chk({diagCycles[2], diagCycles[1], diagCycles[0]}, {3{12'h190}});
        chk({limitActive, activeFreewheel}, 2'h3);
        chk(thresholdCode[2], 6'h05);
        send({4'h1, 4'h1, 2'h2, 22'h0});
        chk(rsp[20:15], 6'h2A);
        chk({diagCycles[0], diagCycles[2]}, {DS[2], DS[0]});
        pulse(3'h4, 3'h0, 1'b0);
        chk({channelShutdown[2], gateCurrent[2]}, {1'b1, GATE_20});
        pulse(3'h0, 3'h4, 1'b0);
        chk(channelShutdown[2], 1'b1);
        pulse(3'h0, 3'h0, 1'b1);
        pulse(3'h0, 3'h4, 1'b0);
        chk({channelShutdown[2], gateCurrent[2]}, {1'b0, GATE_1});
        bridge1Enable <= 1'b0;
        // channel two still holds re-engage after readout and 1 mA gate current
        pulse(3'h6, 3'h0, 1'b0);
        pulse(3'h0, 3'h6, 1'b0);
        chk({channelShutdown[2:1], limitActive, gateCurrent[1]}, {2'b01, 1'b0, GATE_20});
        chk({channelShutdown[2], limitActive}, 2'h0);
        pulse(3'h0, 3'h0, 1'b1);
        pulse(3'h0, 3'h2, 1'b0);
        chk({channelShutdown[1], gateCurrent[1]}, {1'b0, GATE_1});
        report_and_stop();
    end
endmodule
